// ==== dv/csd_dma_properties.sv ====
// Concurrent checks on the DMA top-level ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps

module csd_dma_properties
  import csd_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Register slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic [31:0]        wb_dat_o,
  input  wire logic               wb_ack_o,
  // Memory master and interrupts
  input  wire logic               mem_req_o,
  input  wire logic               mem_we_o,
  input  wire logic               mem_byte_o,
  input  wire csd_pkg::csd_addr_t mem_adr_o,
  input  wire logic               mem_ack_i,
  input  wire logic [1:0]         dma_irq_o
);
  logic [2:0] wr_hist_ff;

  // ========================================================================
  // Helper: recent write completions
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_hist_ff <= 3'h0;
    end else begin
      wr_hist_ff <= {wr_hist_ff[1:0], mem_req_o & mem_we_o & mem_ack_i};
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence wb_take_s;  wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence rd_done_s;  mem_req_o && !mem_we_o && mem_ack_i; endsequence
  sequence wr_done_s;  mem_req_o && mem_we_o && mem_ack_i; endsequence
  sequence wr_start_s; !mem_req_o ##1 (mem_req_o && mem_we_o); endsequence

  // ========================================================================
  // Assertions
  wb_ack_next_a: assert property (wb_take_s |=> wb_ack_o)
    else $error("register access not answered in one cycle");
  wb_ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("register ack longer than one cycle");
  wb_dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  req_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o
    && $stable(mem_adr_o) && $stable(mem_we_o) && $stable(mem_byte_o))
    else $error("memory request changed before ack");
  rd_then_wr_a: assert property (rd_done_s |=> wr_start_s)
    else $error("source read not followed by destination write");
  wr_gap_a: assert property (wr_done_s |=> !mem_req_o [*2])
    else $error("bus not returned after a transfer");
  irq_pulse_a: assert property (|dma_irq_o |=> dma_irq_o == 2'b00)
    else $error("interrupt pulse longer than one cycle");
  irq_cause_a: assert property (|dma_irq_o |-> |wr_hist_ff)
    else $error("interrupt without a finished transfer");
  irq_single_a: assert property (dma_irq_o != 2'b11)
    else $error("both channels signalled at once");
endmodule

bind csd_dma csd_dma_properties u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_req_o(mem_req_o),
  .mem_we_o(mem_we_o), .mem_byte_o(mem_byte_o), .mem_adr_o(mem_adr_o),
  .mem_ack_i(mem_ack_i), .dma_irq_o(dma_irq_o));

// ==== dv/csd_mem_model.sv ====
// Memory behind the DMA master port, with a programmable answer delay.
// Assumes the DMA holds its request until ack and drops it after.
`timescale 1ns/1ps

module csd_mem_model
  import csd_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // DMA side
  input  wire logic               req_i,
  input  wire csd_pkg::csd_addr_t adr_i,
  input  wire logic [1:0]         dly_i,
  output csd_pkg::csd_data_t      rdat_o,
  output logic                    ack_o
);
  import csd_pkg::*;
  logic [1:0] wait_ff;
  logic       fire;

  assign fire = req_i && !ack_o && wait_ff == dly_i;

  // DMA always owns the bus once it asks
  always_ff @(posedge clk_i) begin
    if (rst_i || !fire) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= 1'b1;
    end
    if (rst_i || !req_i || ack_o) begin
      wait_ff <= 2'h0;
    end else if (!fire) begin
      wait_ff <= wait_ff + 2'h1;
    end
  end

  // Data line toggles when idle so stale data is never mistaken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_o <= 16'h0000;
    end else if (fire) begin
      rdat_o <= adr_i[15:0] ^ 16'h5A3C;
    end else begin
      rdat_o <= ~rdat_o;
    end
  end
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the DMA: register tasks plus transfer log.
// Assumes the memory model answers every request of the DMA.
`timescale 1ns/1ps
`include "csd_params.svh"

module tb_top;
  import csd_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [13:0] wb_adr_i = 14'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic        wb_ack_o, mem_req_o, mem_we_o, mem_byte_o, mem_ack_i;
  logic [15:0] c0e = 16'h0, c1b = 16'h0;
  csd_addr_t   mem_adr_o;
  csd_data_t   mem_wdat_o, mem_rdat_i;
  logic [1:0]  dma_irq_o, mem_dly = 2'h0;
  logic [37:0] xlog[$];
  int          miscompares = 0, n_compared = 0, irq0_n = 0, irq1_n = 0;
  int          cycles = 0;

  always #50 clk_i = ~clk_i;

  csd_dma uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ch0_basic_req_i(16'h0), .ch0_ext_req_i(c0e),
    .ch1_basic_req_i(c1b), .ch1_ext_req_i(16'h0), .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o), .mem_byte_o(mem_byte_o), .mem_adr_o(mem_adr_o),
    .mem_wdat_o(mem_wdat_o), .mem_rdat_i(mem_rdat_i),
    .mem_ack_i(mem_ack_i), .dma_irq_o(dma_irq_o));
  csd_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .req_i(mem_req_o),
    .adr_i(mem_adr_o), .dly_i(mem_dly), .rdat_o(mem_rdat_i),
    .ack_o(mem_ack_i));

  // ========================================================================
  // Monitors and timeout
  always @(posedge clk_i) begin
    cycles++;
    if (!rst_i && mem_req_o === 1'b1 && mem_ack_i === 1'b1)
      xlog.push_back({mem_we_o, mem_byte_o, mem_adr_o,
                      mem_we_o ? mem_wdat_o : mem_rdat_i});
    if (!rst_i) begin
      irq0_n += dma_irq_o[0];
      irq1_n += dma_irq_o[1];
    end
    if (cycles == 20000) begin
      miscompares++;
      print_verdict;
    end
  end

  // ========================================================================
  // Tasks
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb_xfer(input logic we, input logic [13:0] a,
                         input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [13:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_xfer(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  task automatic pulse(input logic [15:0] a, input logic [15:0] b);
    @(posedge clk_i);
    c0e <= a;
    c1b <= b;
    @(posedge clk_i);
    c0e <= 16'h0;
    c1b <= 16'h0;
  endtask

  // Pops one read and one write; byte mode compares only the low lane, and nothing for an odd destination
  task automatic xfer(input logic [19:0] s, input logic [19:0] d,
                      input logic b);
    logic [37:0] r;
    logic [37:0] w;
    logic [15:0] m;
    repeat (200) if (xlog.size() < 2) @(posedge clk_i);
    check(xlog.size() > 1, 1);
    if (xlog.size() > 1) begin
      r = xlog.pop_front();
      w = xlog.pop_front();
      m = (b && d[0]) ? 16'h0000 : (b ? 16'h00FF : 16'hFFFF);
      check(r[37:16], {1'b0, b, s});
      check(w[37:16], {1'b1, b, d});
      check(w[15:0] & m, r[15:0] & m);
    end
  endtask

  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ========================================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`CSD_OFF_CH0_CTRL, 32'h0);
    rd(`CSD_OFF_CH1_SEL, 32'h0);
    rd(14'h2FF0, 32'h0);
    wr(`CSD_OFF_CH1_SEL, 32'h03);
    wr(`CSD_OFF_CH1_CTRL, 32'h00);
    pulse(16'h0, 16'h0008);
    rd(`CSD_OFF_CH1_CTRL, 32'h04);
    wr(`CSD_OFF_CH1_CTRL, 32'h04);
    rd(`CSD_OFF_CH1_CTRL, 32'h04);
    wr(`CSD_OFF_CH1_CTRL, 32'h00);
    rd(`CSD_OFF_CH1_CTRL, 32'h00);
    // Software block: two 16-bit units, source forward, far destination
    wr(`CSD_OFF_SRC_BASE, 32'h00100);
    wr(`CSD_OFF_DST_BASE, 32'hF0200);
    wr(`CSD_OFF_RLD_BASE, 32'h1);
    wr(`CSD_OFF_CH0_CTRL, 32'h18);
    wr(`CSD_OFF_CH0_SEL, 32'h81);
    xfer(20'h00100, 20'hF0200, 1'b0);
    rd(`CSD_OFF_CH0_SEL, 32'h01);
    wr(`CSD_OFF_CH0_SEL, 32'h81);
    xfer(20'h00102, 20'hF0200, 1'b0);
    rd(`CSD_OFF_CH0_CTRL, 32'h10);
    rd(`CSD_OFF_CNT_BASE, 32'hFFFF);
    check(irq0_n, 1);
    wr(`CSD_OFF_CH0_SEL, 32'hC1);
    rd(`CSD_OFF_CH0_CTRL, 32'h10);
    // Both channels at once, slow memory; channel 1 repeat, 8-bit
    mem_dly <= 2'h3;
    wr(`CSD_OFF_CH0_SEL, 32'h46);
    wr(`CSD_OFF_RLD_BASE, 32'h0);
    wr(`CSD_OFF_CH0_CTRL, 32'h18);
    wr(`CSD_OFF_SRC_BASE + 14'h40, 32'h00400);
    wr(`CSD_OFF_DST_BASE + 14'h40, 32'h00300);
    wr(`CSD_OFF_RLD_BASE + 14'h40, 32'h0);
    wr(`CSD_OFF_CH1_CTRL, 32'h2B);
    pulse(16'h0040, 16'h0008);
    xfer(20'h00100, 20'hF0200, 1'b0);
    xfer(20'h00400, 20'h00300, 1'b1);
    pulse(16'h0, 16'h0008);
    xfer(20'h00400, 20'h00301, 1'b1);
    rd(`CSD_OFF_CH1_CTRL, 32'h2B);
    check(irq1_n, 2);
    check(irq0_n, 2);
    wr(`CSD_OFF_CH1_CTRL, 32'h2B);
    pulse(16'h0, 16'h0008);
    xfer(20'h00400, 20'h00300, 1'b1);
    wr(`CSD_OFF_CH1_CTRL, 32'h23);
    pulse(16'h0, 16'h0008);
    repeat (40) @(posedge clk_i);
    check(xlog.size(), 0);
    rd(`CSD_OFF_CH1_CTRL, 32'h27);
    print_verdict;
  end
endmodule

// ==== src/csd_dma.sv ====
// Two-channel cycle-steal DMA with a classic Wishbone register slave.
// Assumes a memory bus master port that grants the DMA priority over the
// CPU, and peripheral request pulses synchronous to clk_i.
`timescale 1ns/1ps
`include "csd_params.svh"

module csd_dma
  import csd_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Wishbone register slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [13:0]      wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Peripheral request pulses, one per source code
  input  wire logic [15:0]      ch0_basic_req_i,
  input  wire logic [15:0]      ch0_ext_req_i,
  input  wire logic [15:0]      ch1_basic_req_i,
  input  wire logic [15:0]      ch1_ext_req_i,
  // Memory master (priority over CPU)
  output logic                  mem_req_o,
  output logic                  mem_we_o,
  output logic                  mem_byte_o,
  output csd_pkg::csd_addr_t    mem_adr_o,
  output csd_pkg::csd_data_t    mem_wdat_o,
  input  wire csd_pkg::csd_data_t mem_rdat_i,
  input  wire logic             mem_ack_i,
  // Underflow interrupt pulses
  output logic [1:0]            dma_irq_o
);
  import csd_pkg::*;

  // ========================================================================
  // Source decode
  // Channel 0 extended table only fills 0110b..1001b; channel 1 only 0101b
  // and 0111b. Unlisted extended codes give no request.
  function automatic logic pick_req(input logic [7:0] sel,
                                    input logic [15:0] basic,
                                    input logic [15:0] ext,
                                    input logic [15:0] ext_ok);
    logic [3:0] code;
    code = sel[3:0];
    if (sel[`CSD_SEL_EXP])
      pick_req = ext[code] & ext_ok[code];
    else
      pick_req = basic[code];
  endfunction

  localparam logic [15:0] EXT_OK0 = 16'h03C0;
  localparam logic [15:0] EXT_OK1 = 16'h00A0;

  // ========================================================================
  // Registers
  logic [7:0]  ctl_ff  [2];
  logic [7:0]  sel_ff  [2];
  csd_addr_t   src_ff  [2];
  csd_addr_t   dst_ff  [2];
  csd_cnt_t    rld_ff  [2];
  csd_cnt_t    cnt_ff  [2];
  csd_addr_t   cur_ff  [2];
  logic [1:0]  arm_ff;
  logic [1:0]  swreq;
  logic [1:0]  req;
  logic [1:0]  ctl_wr;
  logic [1:0]  start;
  logic [1:0]  done;

  csd_state_e  state_ff;
  logic        ch_ff;
  csd_data_t   buf_ff;

  logic        wb_req;
  logic        wr_en;
  logic [13:0] a;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en  = wb_req & wb_we_i & wb_sel_i[0];
  assign a      = wb_adr_i;

  // ========================================================================
  // Per-channel request and register logic
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gch
      localparam logic [13:0] OFS = 14'(g) * `CSD_OFF_CH_STRIDE;
      logic [13:0] ctl_a;
      logic [13:0] sel_a;
      assign ctl_a = (g == 0) ? `CSD_OFF_CH0_CTRL : `CSD_OFF_CH1_CTRL;
      assign sel_a = (g == 0) ? `CSD_OFF_CH0_SEL : `CSD_OFF_CH1_SEL;

      // Software trigger needs basic source 0001b
      assign swreq[g] = wr_en && a == sel_a && wb_dat_i[`CSD_SEL_SWREQ]
                        && !wb_dat_i[`CSD_SEL_EXP]
                        && wb_dat_i[3:0] == `CSD_SEL_SW_CODE;
      // Interrupt masks never enter here
      assign req[g] = swreq[g] | pick_req(sel_ff[g],
                        (g == 0) ? ch0_basic_req_i : ch1_basic_req_i,
                        (g == 0) ? ch0_ext_req_i : ch1_ext_req_i,
                        (g == 0) ? EXT_OK0 : EXT_OK1);
      assign ctl_wr[g] = wr_en && a == ctl_a;

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sel_ff[g] <= `CSD_SEL_RESET;
        end else if (wr_en && a == sel_a) begin
          sel_ff[g] <= {1'b0, wb_dat_i[6], 2'b00, wb_dat_i[3:0]};
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ctl_ff[g] <= `CSD_CTL_RESET;
          arm_ff[g] <= 1'b0;
        end else begin
          if (ctl_wr[g]) begin
            ctl_ff[g][1:0] <= wb_dat_i[1:0];
            ctl_ff[g][5:3] <= wb_dat_i[5:3];
            if (!wb_dat_i[`CSD_CTL_PEND])
              ctl_ff[g][`CSD_CTL_PEND] <= 1'b0;
            if (wb_dat_i[`CSD_CTL_EN])
              arm_ff[g] <= 1'b1;
          end
          // A same-cycle enable write re-arms for the next start
          if (start[g]) begin
            ctl_ff[g][`CSD_CTL_PEND] <= 1'b0;
            arm_ff[g] <= ctl_wr[g] && wb_dat_i[`CSD_CTL_EN];
          end
          // Single mode drops enable at underflow
          if (done[g] && cnt_ff[g] == '0 && !ctl_ff[g][`CSD_CTL_REPEAT]
              && !(ctl_wr[g] && wb_dat_i[`CSD_CTL_EN]))
            ctl_ff[g][`CSD_CTL_EN] <= 1'b0;
          // Set wins over clear; requests merge while pending
          if (req[g])
            ctl_ff[g][`CSD_CTL_PEND] <= 1'b1;
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          src_ff[g] <= '0;
          dst_ff[g] <= '0;
          rld_ff[g] <= '0;
        end else if (wr_en) begin
          if (a == `CSD_OFF_SRC_BASE + OFS)
            src_ff[g] <= wb_dat_i[`CSD_AW-1:0];
          if (a == `CSD_OFF_DST_BASE + OFS)
            dst_ff[g] <= wb_dat_i[`CSD_AW-1:0];
          if (a == `CSD_OFF_RLD_BASE + OFS)
            rld_ff[g] <= wb_dat_i[`CSD_CW-1:0];
        end
      end

      // Counter and incrementing pointer
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt_ff[g] <= '0;
          cur_ff[g] <= '0;
        end else if (start[g] && arm_ff[g]) begin
          cnt_ff[g] <= rld_ff[g];
          cur_ff[g] <= ctl_ff[g][`CSD_CTL_SDIR] ? src_ff[g] : dst_ff[g];
        end else if (done[g]) begin
          cnt_ff[g] <= cnt_ff[g] - 16'h0001;
          if (cnt_ff[g] == '0 && ctl_ff[g][`CSD_CTL_REPEAT])
            cnt_ff[g] <= rld_ff[g];
          cur_ff[g] <= cur_ff[g] +
            (ctl_ff[g][`CSD_CTL_UNIT] ? 20'h00001 : 20'h00002);
        end
      end
    end
  endgenerate

  // ========================================================================
  // Arbiter and transfer engine
  logic [1:0] ready;
  logic       any_ready;
  logic       win;
  assign ready[0] = ctl_ff[0][`CSD_CTL_PEND] & ctl_ff[0][`CSD_CTL_EN];
  assign ready[1] = ctl_ff[1][`CSD_CTL_PEND] & ctl_ff[1][`CSD_CTL_EN];
  assign any_ready = |ready;
  assign win = ~ready[0];
  assign start[0] = state_ff == CSD_IDLE && ready[0];
  assign start[1] = state_ff == CSD_IDLE && !ready[0] && ready[1];
  assign done[0] = state_ff == CSD_DONE && !ch_ff;
  assign done[1] = state_ff == CSD_DONE && ch_ff;

  // Effective addresses: the working pointer if that side increments
  csd_addr_t s_adr;
  csd_addr_t d_adr;
  logic      c_sd;
  logic      c_dd;
  assign c_sd  = ctl_ff[ch_ff][`CSD_CTL_SDIR];
  assign c_dd  = ctl_ff[ch_ff][`CSD_CTL_DDIR];
  assign s_adr = c_sd ? cur_ff[ch_ff] : src_ff[ch_ff];
  assign d_adr = c_dd ? cur_ff[ch_ff] : dst_ff[ch_ff];

  // Transfer is read then write; only mem bus touched, no IRQ flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff   <= CSD_IDLE;
      ch_ff      <= 1'b0;
      buf_ff     <= '0;
      mem_req_o  <= 1'b0;
      mem_we_o   <= 1'b0;
      mem_byte_o <= 1'b0;
      mem_adr_o  <= '0;
      mem_wdat_o <= '0;
    end else begin
      case (state_ff)
        CSD_IDLE: begin
          if (any_ready) begin
            ch_ff    <= win;
            state_ff <= CSD_READ;
          end
        end
        CSD_READ: begin
          if (!mem_req_o) begin
            mem_req_o  <= 1'b1;
            mem_we_o   <= 1'b0;
            mem_byte_o <= ctl_ff[ch_ff][`CSD_CTL_UNIT];
            mem_adr_o  <= s_adr;
          end else if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            buf_ff    <= mem_rdat_i;
            state_ff  <= CSD_WRITE;
          end
        end
        CSD_WRITE: begin
          if (!mem_req_o) begin
            mem_req_o  <= 1'b1;
            mem_we_o   <= 1'b1;
            mem_adr_o  <= d_adr;
            mem_wdat_o <= buf_ff;
          end else if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            mem_we_o  <= 1'b0;
            state_ff  <= CSD_DONE;
          end
        end
        CSD_DONE: begin
          state_ff <= CSD_IDLE;
        end
        default: begin
          state_ff <= CSD_IDLE;
        end
      endcase
    end
  end

  // Underflow interrupt, both modes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dma_irq_o <= 2'b00;
    end else begin
      dma_irq_o[0] <= done[0] && cnt_ff[0] == '0;
      dma_irq_o[1] <= done[1] && cnt_ff[1] == '0;
    end
  end

  // ========================================================================
  // Wishbone read mux and ack
  function automatic logic [31:0] rd_mux(input logic [13:0] ad);
    rd_mux = 32'h0000_0000;
    for (int c = 0; c < 2; c++) begin
      if (ad == `CSD_OFF_SRC_BASE + 14'(c) * `CSD_OFF_CH_STRIDE)
        rd_mux = {12'h000, src_ff[c]};
      if (ad == `CSD_OFF_DST_BASE + 14'(c) * `CSD_OFF_CH_STRIDE)
        rd_mux = {12'h000, dst_ff[c]};
      if (ad == `CSD_OFF_RLD_BASE + 14'(c) * `CSD_OFF_CH_STRIDE)
        rd_mux = {16'h0000, rld_ff[c]};
      if (ad == `CSD_OFF_CNT_BASE + 14'(c) * `CSD_OFF_CH_STRIDE)
        rd_mux = {16'h0000, cnt_ff[c]};
      if (ad == `CSD_OFF_CUR_BASE + 14'(c) * `CSD_OFF_CH_STRIDE)
        rd_mux = {12'h000, cur_ff[c]};
    end
    if (ad == `CSD_OFF_CH0_CTRL) rd_mux = {24'h000000, ctl_ff[0]};
    if (ad == `CSD_OFF_CH1_CTRL) rd_mux = {24'h000000, ctl_ff[1]};
    if (ad == `CSD_OFF_CH0_SEL)  rd_mux = {24'h000000, sel_ff[0]};
    if (ad == `CSD_OFF_CH1_SEL)  rd_mux = {24'h000000, sel_ff[1]};
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      // Unmapped addresses ack with zero data
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_mux(a) : 32'h0000_0000;
    end
  end

endmodule

// ==== src/csd_params.svh ====
// Register offsets, field positions and reset values for the DMA.
// Included by the package, the DMA module and the bench; definitions only.
`ifndef CSD_PARAMS_SVH
`define CSD_PARAMS_SVH

// ==========================================================================
// Register byte offsets (printed offsets are not all word aligned: index*4)
`define CSD_IDX_CH0_CTRL     12'h02C
`define CSD_IDX_CH1_CTRL     12'h03C
`define CSD_IDX_CH0_SEL      12'h3B8
`define CSD_IDX_CH1_SEL      12'h3BA
`define CSD_OFF_CH0_CTRL     14'h00B0
`define CSD_OFF_CH1_CTRL     14'h00F0
`define CSD_OFF_CH0_SEL      14'h0EE0
`define CSD_OFF_CH1_SEL      14'h0EE8
// Pointer, reload and counter registers, base + ch*0x40
`define CSD_OFF_SRC_BASE     14'h1000
`define CSD_OFF_DST_BASE     14'h1004
`define CSD_OFF_RLD_BASE     14'h1008
`define CSD_OFF_CNT_BASE     14'h100C
`define CSD_OFF_CUR_BASE     14'h1010
`define CSD_OFF_CH_STRIDE    14'h0040

// ==========================================================================
// Control register fields
`define CSD_CTL_UNIT         0
`define CSD_CTL_REPEAT       1
`define CSD_CTL_PEND         2
`define CSD_CTL_EN           3
`define CSD_CTL_SDIR         4
`define CSD_CTL_DDIR         5
// Select register fields and reset values
`define CSD_SEL_EXP          6
`define CSD_SEL_SWREQ        7
`define CSD_SEL_SW_CODE      4'h1
`define CSD_CTL_RESET        8'h00
`define CSD_SEL_RESET        8'h00

// ==========================================================================
// Widths
`define CSD_AW               20
`define CSD_DW               16
`define CSD_CW               16
`define CSD_NSRC             16

`endif

// ==== src/csd_pkg.sv ====
// Types shared by the DMA module and its bench.
// Assumes csd_params.svh is on the include path.
`include "csd_params.svh"

package csd_pkg;
  typedef logic [`CSD_AW-1:0] csd_addr_t;
  typedef logic [`CSD_DW-1:0] csd_data_t;
  typedef logic [`CSD_CW-1:0] csd_cnt_t;

  // Transfer engine states, one-hot
  typedef enum logic [3:0] {
    CSD_IDLE  = 4'b0001,
    CSD_READ  = 4'b0010,
    CSD_WRITE = 4'b0100,
    CSD_DONE  = 4'b1000
  } csd_state_e;
endpackage
